// *** inc/home_pkg.sv ***
// What this block does
// - Stop commands 56h/57h abort the search
// - Stop during inter-step timer halts timer
// - Busy bit set from start until the search returns to idle
// - Error sets axis error bit and cause bits
// - Six-bit state field in bits 14..9
// - States 0, 3, 6 for idle, step1, timer
// - Step 2 states 11, 15, 18, 20
// - States 23, 28, 32, 36 for steps 3-4
// - Servo alarm stops search, cause bit 4
// - Emergency stop stops search, cause bit 5
// - Step 3 limit stops, limit cause bit
// - Step 4 limit stops offset, limit cause
// - Z-phase active at Step 3 start errors
// - Steps 1-2 limit stops without error, except reverse limit in Step 2 escape
// - Step 1 input active skips to Step 2
// - Step 1 limit leads to Step 2 reverse search
// - Step 2 stuck input ends on reverse limit
// - Missing Z-phase ends Step 3 on limit
package home_pkg;
    // ========================================
    // Commands
    localparam logic [7:0] CMD_HOME    = 8'h5a;
    localparam logic [7:0] CMD_DEC_STP = 8'h56;
    localparam logic [7:0] CMD_INS_STP = 8'h57;
    // ========================================
    // Register offsets
    localparam logic [1:0] ADDR_CMD    = 2'h0;
    localparam logic [1:0] ADDR_MAIN   = 2'h0;
    localparam logic [1:0] ADDR_MODE   = 2'h1;
    localparam logic [1:0] ADDR_CAUSE  = 2'h2;
    localparam logic [1:0] ADDR_STATE  = 2'h3;
    // ========================================
    // Field positions
    localparam int BUSY_BIT   = 0;
    localparam int ERR_BIT    = 4;
    localparam int CAUSE_LMP  = 2;
    localparam int CAUSE_LMM  = 3;
    localparam int CAUSE_ALM  = 4;
    localparam int CAUSE_EMG  = 5;
    localparam int CAUSE_ZPH  = 6;
    localparam int STATE_LSB  = 9;
    localparam int MODE_S1EN  = 0;
    localparam int MODE_S2EN  = 1;
    localparam int MODE_S3EN  = 2;
    localparam int MODE_S4EN  = 3;
    localparam int MODE_TMEN  = 4;
    localparam int MODE_DIR   = 5;
    localparam logic [15:0] MODE_RST = 16'h000f;
    // ========================================
    // Timing
    localparam int CLK_HZ       = 25000000;
    localparam int TIMER_US     = 1000;
    localparam int TIMER_CYC    = (CLK_HZ / 1000000) * TIMER_US;
    // ========================================
    // Execution states
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000000,
        ST_S1     = 6'b000011,
        ST_T12    = 6'b000110,
        ST_S2REV  = 6'b001011,
        ST_S2ESC  = 6'b001111,
        ST_T2R    = 6'b010010,
        ST_S2FWD  = 6'b010100,
        ST_T23    = 6'b010111,
        ST_S3     = 6'b011100,
        ST_T34    = 6'b100000,
        ST_S4     = 6'b100100
    } srch_state_e;
    typedef struct packed {
        logic near_home;
        logic home;
        logic z_phase;
        logic lim_p;
        logic lim_m;
        logic alarm;
        logic emg;
    } sens_s;
endpackage : home_pkg

// *** hw/step_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Inter-step timer: counts while run, pulses done
module step_timer #(
    parameter int CYCLES = 25000
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      done
);
    logic [31:0] cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 32'h0;
            done  <= 1'b0;
        end else if (!run) begin
            cnt_r <= 32'h0;
            done  <= 1'b0;
        end else begin
            done  <= (cnt_r == 32'(CYCLES - 2));
            cnt_r <= cnt_r + 32'h1;
        end
    end
endmodule : step_timer
`default_nettype wire

// *** hw/home_search.sv ***
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Home search supervisor for one axis
module home_search
    import home_pkg::*;
#(
    parameter int TIMER_CYCLES = TIMER_CYC
) (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    // Register port
    input  wire logic [1:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    // Sensors, active high after input logic
    input  wire logic        NEAR_HOME,
    input  wire logic        HOME,
    input  wire logic        ZPHASE,
    input  wire logic        LIMIT_P,
    input  wire logic        LIMIT_M,
    input  wire logic        ALARM,
    input  wire logic        EMG_STOP,
    // Motion request to the pulse generator
    output logic             DRIVE,
    output logic             DIR_PLUS,
    output logic             STOP_INSTANT
);
    // ========================================
    // State
    srch_state_e state_r, state_nxt;
    logic        busy_r, err_r;
    logic [6:0]  cause_r;
    logic [15:0] mode_r;
    logic        z_prev_r;
    logic        s3_new_r;
    logic        tmr_done;
    logic        tmr_run;
    sens_s       sn;
    logic        cmd_home, cmd_stop;
    logic        dir;
    logic        lim_fwd, lim_rev;
    logic [6:0]  err_set;
    logic        fail;

    assign sn = '{NEAR_HOME, HOME, ZPHASE, LIMIT_P, LIMIT_M, ALARM, EMG_STOP};
    assign dir = mode_r[MODE_DIR];
    assign cmd_home = WR && (ADDR == ADDR_CMD) && (WDATA[7:0] == CMD_HOME);
    assign cmd_stop = WR && (ADDR == ADDR_CMD) &&
                      (WDATA[7:0] == CMD_DEC_STP || WDATA[7:0] == CMD_INS_STP);
    assign lim_fwd = dir ? sn.lim_p : sn.lim_m;
    assign lim_rev = dir ? sn.lim_m : sn.lim_p;

    // Timer runs only in timer states; leaving them halts it
    assign tmr_run = (state_r == ST_T12) || (state_r == ST_T2R) ||
                     (state_r == ST_T23) || (state_r == ST_T34);

    step_timer #(
        .CYCLES (TIMER_CYCLES)
    ) u_tmr (
        .clk  (SYS_CLK),
        .rst  (RST),
        .run  (tmr_run),
        .done (tmr_done)
    );

    // Limit bit of whichever direction is being driven
    function automatic logic [6:0] lim_cause(input logic plus);
        lim_cause = 7'h0;
        lim_cause[plus ? CAUSE_LMP : CAUSE_LMM] = 1'b1;
    endfunction : lim_cause

    // Next step after a finished one, honouring the step enables only
    function automatic srch_state_e after_step(input int step, input logic [15:0] m);
        srch_state_e t;
        t = ST_IDLE;
        if (step < 2 && m[MODE_S2EN]) begin
            t = ST_S2FWD;
        end else if (step < 3 && m[MODE_S3EN]) begin
            t = ST_S3;
        end else if (step < 4 && m[MODE_S4EN]) begin
            t = ST_S4;
        end
        after_step = t;
    endfunction : after_step

    // ========================================
    // Error detection
    always_comb begin
        err_set = 7'h0;
        if (state_r != ST_IDLE) begin
            if (sn.alarm) begin
                err_set[CAUSE_ALM] = 1'b1;
            end
            if (sn.emg) begin
                err_set[CAUSE_EMG] = 1'b1;
            end
            if ((state_r == ST_S3 || state_r == ST_S4) && lim_fwd) begin
                err_set = err_set | lim_cause(dir);
            end
            if (state_r == ST_S2ESC && lim_rev) begin
                err_set = err_set | lim_cause(!dir);
            end
            // Step 3 may be entered from idle or any earlier step, so test Z in its first cycle
            if (state_r == ST_S3 && s3_new_r && sn.z_phase) begin
                err_set[CAUSE_ZPH] = 1'b1;
            end
        end
    end
    assign fail = |err_set;

    // ========================================
    // Sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (cmd_home) begin
                    if (mode_r[MODE_S1EN] && !sn.near_home) begin
                        state_nxt = ST_S1;
                    end else begin
                        state_nxt = after_step(1, mode_r);
                    end
                    if (state_nxt == ST_S2FWD && sn.home) begin
                        state_nxt = ST_S2ESC;
                    end
                end
            end
            ST_S1: begin
                if (sn.near_home || lim_fwd) begin
                    state_nxt = ST_T12;
                end
            end
            ST_T12: begin
                if (tmr_done || !mode_r[MODE_TMEN]) begin
                    state_nxt = sn.home ? ST_S2ESC : ST_S2REV;
                    if (!mode_r[MODE_S2EN]) begin
                        state_nxt = after_step(2, mode_r);
                    end
                end
            end
            ST_S2REV: begin
                if (sn.home || lim_rev) begin
                    state_nxt = ST_S2ESC;
                end
            end
            ST_S2ESC: begin
                if (!sn.home) begin
                    state_nxt = ST_T2R;
                end
            end
            ST_T2R: begin
                if (tmr_done || !mode_r[MODE_TMEN]) begin
                    state_nxt = ST_S2FWD;
                end
            end
            ST_S2FWD: begin
                if (sn.home) begin
                    state_nxt = ST_T23;
                end else if (lim_fwd) begin
                    state_nxt = ST_S2REV;
                end
            end
            ST_T23: begin
                if (tmr_done || !mode_r[MODE_TMEN]) begin
                    state_nxt = after_step(2, mode_r);
                end
            end
            ST_S3: begin
                if (sn.z_phase && !z_prev_r) begin
                    state_nxt = ST_T34;
                end
            end
            ST_T34: begin
                if (tmr_done || !mode_r[MODE_TMEN]) begin
                    state_nxt = after_step(3, mode_r);
                end
            end
            ST_S4: begin
                if (!DRIVE) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        // Abort wins over every step transition
        if (state_r != ST_IDLE && (cmd_stop || fail)) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_r  <= ST_IDLE;
            z_prev_r <= 1'b0;
            s3_new_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            z_prev_r <= sn.z_phase;
            s3_new_r <= (state_nxt == ST_S3) && (state_r != ST_S3);
        end
    end

    // ========================================
    // Busy, error and cause
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (state_nxt != ST_IDLE);
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            err_r   <= 1'b0;
            cause_r <= 7'h0;
        end else if (state_r == ST_IDLE && cmd_home) begin
            err_r   <= 1'b0;
            cause_r <= 7'h0;
        end else if (fail) begin
            err_r   <= 1'b1;
            cause_r <= cause_r | err_set;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            mode_r <= MODE_RST;
        end else if (WR && ADDR == ADDR_MODE && state_r == ST_IDLE) begin
            mode_r <= WDATA;
        end
    end

    // ========================================
    // Drive request: offset move is a fixed-length drive owned elsewhere,
    // so Step 4 ends when the drive request drops after one cycle here
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            DRIVE        <= 1'b0;
            DIR_PLUS     <= 1'b0;
            STOP_INSTANT <= 1'b0;
        end else begin
            DRIVE <= (state_nxt == ST_S1) || (state_nxt == ST_S2REV) ||
                     (state_nxt == ST_S2ESC) || (state_nxt == ST_S2FWD) ||
                     (state_nxt == ST_S3) ||
                     (state_nxt == ST_S4 && state_r != ST_S4);
            DIR_PLUS <= ((state_nxt == ST_S2REV) || (state_nxt == ST_S2ESC)) ? !dir : dir;
            STOP_INSTANT <= (sn.alarm || sn.emg || (cmd_stop &&
                            WDATA[7:0] == CMD_INS_STP)) && state_r != ST_IDLE;
        end
    end

    // ========================================
    // Read port
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 16'h0;
        end else if (RD) begin
            if (ADDR == ADDR_MAIN) begin
                RDATA <= 16'h0;
                RDATA[BUSY_BIT] <= busy_r;
                RDATA[ERR_BIT]  <= err_r;
            end else if (ADDR == ADDR_MODE) begin
                RDATA <= mode_r;
            end else if (ADDR == ADDR_CAUSE) begin
                RDATA <= {9'h0, cause_r};
            end else begin
                RDATA <= {1'b0, state_r, 9'h0};
            end
        end else begin
            RDATA <= 16'h0;
        end
    end
endmodule : home_search
`default_nettype wire

// *** sim/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Host side of the register port
module host_model (
    // Clock
    input  wire logic        clk,
    // Register port
    output logic      [1:0]  addr,
    output logic      [15:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [15:0] rdata
);
    initial begin
        addr  = 2'h0;
        wdata = 16'h0000;
        wr    = 1'b0;
        rd    = 1'b0;
    end
    // One-cycle write; a search is only started after its mode word
    task automatic write_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : write_reg
    // Data stand only in the cycle after the strobe, so take them mid-cycle
    task automatic read_reg(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : read_reg
endmodule : host_model
`default_nettype wire

// *** sim/home_search_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Port checks for the home search block
module home_search_asserts
    import home_pkg::*;
(
    input wire logic        SYS_CLK,
    input wire logic        RST,
    input wire logic [1:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic        ALARM,
    input wire logic        EMG_STOP,
    input wire logic        DRIVE,
    input wire logic        STOP_INSTANT
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    logic stop_wr;
    assign stop_wr = WR && ADDR == ADDR_CMD
                     && (WDATA[7:0] == CMD_DEC_STP || WDATA[7:0] == CMD_INS_STP);
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_state_legal: assert property ($past(RD) && $past(ADDR) == ADDR_STATE |->
        RDATA[8:0] == 9'h000 && !RDATA[15]
        && RDATA[14:9] inside {0, 3, 6, 11, 15, 18, 20, 23, 28, 32, 36})
        else $error("state field holds an unlisted value");
    a_cause_field: assert property ($past(RD) && $past(ADDR) == ADDR_CAUSE |->
        RDATA[15:7] == 9'h000 && RDATA[1:0] == 2'h0)
        else $error("cause bits outside their field");
    a_busy_drive: assert property ($past(RD) && $past(ADDR) == ADDR_MAIN
        && $past(DRIVE, 2) && $past(DRIVE) && DRIVE |-> RDATA[BUSY_BIT])
        else $error("busy clear while driving");
    a_alarm_halt: assert property (ALARM && DRIVE |-> ##[1:2] !DRIVE)
        else $error("drive kept after alarm");
    a_emg_halt: assert property (EMG_STOP && DRIVE |-> ##[1:2] !DRIVE)
        else $error("drive kept after emergency");
    a_alarm_instant: assert property (ALARM && DRIVE |-> ##[1:2] STOP_INSTANT)
        else $error("alarm stop not instant");
    a_emg_instant: assert property (EMG_STOP && DRIVE |-> ##[1:2] STOP_INSTANT)
        else $error("emergency stop not instant");
    a_stop_cmd: assert property (stop_wr && DRIVE |-> ##[1:2] !DRIVE)
        else $error("drive kept after stop command");
endmodule : home_search_asserts
bind home_search home_search_asserts chk (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .ALARM(ALARM), .EMG_STOP(EMG_STOP),
    .DRIVE(DRIVE), .STOP_INSTANT(STOP_INSTANT));
`default_nettype wire

// *** sim/home_search_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Home search bench
module home_search_tb_top
    import home_pkg::*;
();
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        wr;
    logic        rd;
    logic        drive;
    logic        dir_plus;
    sens_s       sens = '0;
    int          n_mismatch = 0;
    int          checks = 0;
    int          exp_cause;
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    // Short timer so that a stop can land inside it
    home_search #(.TIMER_CYCLES(40)) uut (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .NEAR_HOME(sens.near_home),
        .HOME(sens.home), .ZPHASE(sens.z_phase), .LIMIT_P(sens.lim_p),
        .LIMIT_M(sens.lim_m), .ALARM(sens.alarm), .EMG_STOP(sens.emg), .DRIVE(drive),
        .DIR_PLUS(dir_plus), .STOP_INSTANT());
    host_model host (.clk(sys_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    // ========================================
    // Helpers
    function automatic logic [15:0] sv(input srch_state_e s);
        return {1'b0, s, 9'h000};
    endfunction : sv
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic rd_chk(input logic [1:0] a, input logic [15:0] e);
        logic [15:0] g;
        host.read_reg(a, g);
        chk(g, e);
    endtask : rd_chk
    task automatic cmp_status(input int err, input int cause);
        rd_chk(ADDR_MAIN, 16'(err << ERR_BIT));
        rd_chk(ADDR_CAUSE, 16'(cause));
    endtask : cmp_status
    task automatic start(input logic [15:0] m);
        host.write_reg(ADDR_MODE, m);
        host.write_reg(ADDR_CMD, {8'h00, CMD_HOME});
    endtask : start
    // Either stop code, picked at random
    task automatic stop();
        host.write_reg(ADDR_CMD, {8'h00, ($urandom % 2) ? CMD_INS_STP : CMD_DEC_STP});
    endtask : stop
    // Bounded poll; a search that never ends shows as a mismatch
    task automatic wait_idle();
        logic [15:0] g;
        for (int k = 0; k < 200; k++) begin
            host.read_reg(ADDR_STATE, g);
            if (g[14:9] === 6'h00) return;
        end
        chk(g, 16'h0000);
    endtask : wait_idle
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    // ========================================
    // Watchdog
    initial begin
        #(40 * 20000);
        n_mismatch++;
        report_and_stop();
    end
    // ========================================
    // Tests
    initial begin
        void'($urandom(73));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        cmp_status(0, 0);
        rd_chk(ADDR_STATE, 16'h0000);
        rd_chk(ADDR_MODE, MODE_RST);
        start(MODE_RST);
        rd_chk(ADDR_STATE, sv(ST_S1));
        chk({15'h0000, drive}, 16'h0001);
        host.write_reg(ADDR_CMD, {8'h00, CMD_HOME});
        rd_chk(ADDR_STATE, sv(ST_S1));
        rd_chk(ADDR_MAIN, 16'h0001 << BUSY_BIT);
        repeat ($urandom_range(1, 9)) @(posedge sys_clk);
        stop();
        wait_idle();
        cmp_status(0, 0);
        // Alarm then emergency; the second start must clear the first cause
        for (int i = 0; i < 2; i++) begin
            start(MODE_RST);
            rd_chk(ADDR_CAUSE, 16'h0000);
            @(posedge sys_clk);
            if (i == 0) sens.alarm <= 1'b1;
            else sens.emg <= 1'b1;
            wait_idle();
            @(posedge sys_clk);
            sens <= '0;
            exp_cause = (i == 0) ? (1 << CAUSE_ALM) : (1 << CAUSE_EMG);
            cmp_status(1, exp_cause);
        end
        // Stop while the inter-step timer runs
        start(MODE_RST | (16'h0001 << MODE_TMEN));
        @(posedge sys_clk);
        sens.near_home <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd_chk(ADDR_STATE, sv(ST_T12));
        stop();
        rd_chk(ADDR_STATE, 16'h0000);
        cmp_status(0, 0);
        // Z-phase already on when Step 3 begins
        @(posedge sys_clk);
        sens <= '{z_phase: 1'b1, default: 1'b0};
        start(16'h0001 << MODE_S3EN);
        wait_idle();
        cmp_status(1, 1 << CAUSE_ZPH);
        // Z-phase never comes: Step 3 ends on the search-direction limit
        @(posedge sys_clk);
        sens <= '{lim_m: 1'b1, default: 1'b0};
        start(16'h0001 << MODE_S3EN);
        wait_idle();
        cmp_status(1, 1 << CAUSE_LMM);
        // Step 1 input already on: Step 1 is skipped, plus direction
        @(posedge sys_clk);
        sens <= '{near_home: 1'b1, default: 1'b0};
        start(MODE_RST | (16'h0001 << MODE_DIR));
        rd_chk(ADDR_STATE, sv(ST_S2FWD));
        chk({15'h0000, dir_plus}, 16'h0001);
        stop();
        wait_idle();
        cmp_status(0, 0);
        report_and_stop();
    end
endmodule : home_search_tb_top
`default_nettype wire
